// ===== rtl/sequencer_pkg.sv
// Constants and types for the start-up timeout and soft-off controller.
// Assumes a 10 MHz core clock and an SMBus-style command link.
package sequencer_pkg;

   // ****************************************
   // Command codes
   // ****************************************
   localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
   localparam logic [7:0] CMD_FAULT_ACTION = 8'h63;
   localparam logic [7:0] CMD_TURNOFF_DELAY_TIME   = 8'h64;
   localparam logic [7:0] CMD_TURNOFF_FALL_TIME    = 8'h65;
   localparam logic [7:0] CMD_STATUS_BYTE  = 8'h78;
   localparam logic [7:0] CMD_STATUS_WORD  = 8'h79;
   localparam logic [7:0] CMD_STATUS_VOUT  = 8'h7a;
   localparam logic [7:0] CMD_STATUS_CML   = 8'h7e;

   // ****************************************
   // Field layouts and codes
   // ****************************************
   localparam int ACT_HI   = 7;
   localparam int ACT_LO   = 6;
   localparam int RETRY_HI = 5;
   localparam int RETRY_LO = 3;
   localparam int DLY_HI   = 2;
   localparam int DLY_LO   = 0;
   localparam int EXP_HI   = 15;
   localparam int EXP_LO   = 11;
   localparam int MAN_HI   = 10;
   localparam logic [1:0] ACTION_IGNORE  = 2'h0;
   localparam logic [1:0] ACTION_DELAYED = 2'h1;
   localparam logic [1:0] ACTION_NOW     = 2'h2;
   localparam logic [2:0] RETRY_LATCH    = 3'h0;
   localparam logic [2:0] RETRY_FOREVER  = 3'h7;
   localparam logic [4:0]  TOFF_DLY_EXP_RST = 5'h1f;
   localparam logic [4:0]  FALL_EXP_RST     = 5'h1e;
   localparam logic [10:0] TOFF_DLY_MAN_MAX = 11'h0ff;
   localparam logic [10:0] FALL_MAN_MAX     = 11'h07f;
   localparam logic [10:0] FALL_MAN_MIN     = 11'h002;
   localparam int SB_OFF      = 6;
   localparam int SB_CML      = 1;
   localparam int SB_NOTA     = 0;
   localparam int SW_VOUT     = 15;
   localparam int SV_STARTUP_TIMEOUT  = 2;
   localparam int SC_BAD_CMD  = 7;
   localparam int SC_BAD_DATA = 6;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_MHZ             = 10;
   localparam int QUARTER_MS_US       = 250;
   localparam int QMS_CYCLES          = QUARTER_MS_US * CLK_MHZ;
   localparam int INTERNAL_OFF_US     = 50;
   localparam int INTERNAL_OFF_CYCLES = INTERNAL_OFF_US * CLK_MHZ;

   // ****************************************
   // State encodings
   // ****************************************
   typedef enum logic [2:0] {
      ST_OFF = 3'h0, ST_START = 3'h1, ST_RUN = 3'h3, ST_TOFF_DLY = 3'h2,
      ST_TURNOFF_FALL_TIME = 3'h6, ST_FLT_DLY = 3'h7, ST_HICCUP = 3'h5, ST_LATCHED = 3'h4
   } state_t;

   typedef enum logic [2:0] {
      T_IDLE = 3'h0, T_ADDR = 3'h1, T_AACK = 3'h3, T_WR = 3'h2,
      T_WACK = 3'h6, T_RD = 3'h7, T_RACK = 3'h5
   } link_state_t;

endpackage : sequencer_pkg

// ===== rtl/smb_byte_if.sv
// Byte-level carrier between the link target and the command logic.
// Assumes both ends run on the same core clock.
interface smb_byte_if;
   logic       start;
   logic       stop;
   logic       wr_valid;
   logic [7:0] wr_byte;
   logic       rd_req;
   logic [7:0] rd_byte;
   modport link (output start, stop, wr_valid, wr_byte, rd_req, input rd_byte);
   modport regs (input start, stop, wr_valid, wr_byte, rd_req, output rd_byte);
endinterface : smb_byte_if

// ===== rtl/smb_target.sv
// Bit-level two-wire target: start/stop, address match, byte shift, acks.
// Assumes the clock and data pins are open-drain and asynchronous to clk_in.
module smb_target #(
   parameter logic [6:0] ADDR = 7'h40
) (
   input  wire logic  clk_in,
   input  wire logic  rst_in,
   input  wire logic  scl_in,
   input  wire logic  sda_in,
   output logic       sda_oe_out,
   smb_byte_if.link   bus
);
   import sequencer_pkg::*;

   typedef struct packed {
      logic        scl_s1, scl_s2, scl_q, sda_s1, sda_s2, sda_q;
      link_state_t st;
      logic [3:0]  bits;
      logic [7:0]  sh;
      logic        oe, start, stop, wr_valid, rd_req;
   } tgt_t;

   tgt_t s, n;
   logic rise, fall;

   always_comb begin
      n = s;
      n.scl_s1 = scl_in;
      n.scl_s2 = s.scl_s1;
      n.scl_q  = s.scl_s2;
      n.sda_s1 = sda_in;
      n.sda_s2 = s.sda_s1;
      n.sda_q  = s.sda_s2;
      n.start = 1'b0;
      n.stop = 1'b0;
      n.wr_valid = 1'b0;
      n.rd_req = 1'b0;
      rise = s.scl_s2 & ~s.scl_q;
      fall = ~s.scl_s2 & s.scl_q;
      if (s.scl_s2 && s.scl_q && s.sda_q && !s.sda_s2) begin
         n.st = T_ADDR;
         n.bits = 4'h0;
         n.oe = 1'b0;
         n.start = 1'b1;
      end else if (s.scl_s2 && s.scl_q && !s.sda_q && s.sda_s2) begin
         n.st = T_IDLE;
         n.oe = 1'b0;
         n.stop = (s.st != T_IDLE);
      end else begin
         unique case (s.st)
            T_IDLE: begin
            end
            T_ADDR, T_WR: begin
               if (rise) begin
                  n.sh = {s.sh[6:0], s.sda_s2};
                  n.bits = s.bits + 4'h1;
               end else if (fall && s.bits == 4'h8) begin
                  n.bits = 4'h0;
                  n.oe = 1'b1;
                  if (s.st == T_WR) begin
                     n.wr_valid = 1'b1;
                     n.st = T_WACK;
                  end else if (s.sh[7:1] == ADDR) begin
                     // Read data is fetched during the ack bit
                     n.rd_req = s.sh[0];
                     n.st = T_AACK;
                  end else begin
                     n.oe = 1'b0;
                     n.st = T_IDLE;
                  end
               end
            end
            T_AACK, T_WACK: begin
               if (fall) begin
                  if (s.st == T_AACK && s.sh[0]) begin
                     n.sh = bus.rd_byte;
                     n.oe = ~bus.rd_byte[7];
                     n.bits = 4'h1;
                     n.st = T_RD;
                  end else begin
                     n.oe = 1'b0;
                     n.st = T_WR;
                  end
               end
            end
            T_RD: begin
               if (fall) begin
                  if (s.bits == 4'h8) begin
                     n.oe = 1'b0;
                     n.st = T_RACK;
                  end else begin
                     n.sh = {s.sh[6:0], 1'b0};
                     n.oe = ~s.sh[6];
                     n.bits = s.bits + 4'h1;
                  end
               end
            end
            T_RACK: begin
               if (rise) begin
                  // A nack from the host ends the read
                  if (!s.sda_s2) begin
                     n.rd_req = 1'b1;
                     n.bits = 4'h0;
                  end else begin
                     n.st = T_IDLE;
                  end
               end else if (fall && s.bits == 4'h0) begin
                  n.sh = bus.rd_byte;
                  n.oe = ~bus.rd_byte[7];
                  n.bits = 4'h1;
                  n.st = T_RD;
               end
            end
            default: n.st = T_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s <= '{scl_s1: 1'b1, scl_s2: 1'b1, scl_q: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1,
                sda_q: 1'b1, st: T_IDLE, bits: 4'h0, sh: 8'h00, default: 1'b0};
      end else begin
         s <= n;
      end
   end

   assign sda_oe_out   = s.oe;
   assign bus.start    = s.start;
   assign bus.stop     = s.stop;
   assign bus.wr_valid = s.wr_valid;
   assign bus.wr_byte  = s.sh;
   assign bus.rd_req   = s.rd_req;

endmodule : smb_target

// ===== rtl/startup_timeout_and_soft_off_ctrl.sv
// Start-up timeout response, retry/hiccup policy and soft turn-off timing.
// Assumes on/off and turn-on-delay status come from logic on clk_in; the
// voltage comparator and the two-wire link pins are asynchronous.
//
// Notes on behaviour
// - Timeout fault sets catch-all, word output-voltage and timeout status bits.
// - Timeout fault also raises the host alert line.
// - Action bits 7:6 of byte register; 00 ignores fault, keeps converting.
// - Action 01 keeps running for the delay, then shuts down and applies retry policy.
// - Action 10 shuts down at once, then applies retry policy.
// - Invalid write, including action 11, flags communication status and alerts.
// - Retry bits 5:3 equal zero means latch off, no restart.
// - Retry 1 to 6: hiccup wait then restart, up to that many times.
// - Delay bits 2:0 zero: 1 ms shutdown delay, hiccup equals rise time.
// - Delay 1 to 7: 1 to 7 ms delay, hiccup two to seven rise times.
// - Turn-off delay register sets ms from stop condition to start of the ramp.
// - Turn-off delay is linear: exponent 15:11 resets 11111b, mantissa 10:0.
// - Turn-off delay 0 to 127.5 ms in 0.5 ms steps; beyond is invalid.
// - An internal delay up to 50 us is added, even for zero.
// - Fall-time register sets ramp time from delay end to zero reference.
// - Ramp lasts the fall time whatever the target; slope from target voltage.
// - Fall-time exponent resets 11110b: exponent -2, 0.25 ms per count.
// - Fall 0.5 to 31.75 ms in 0.25 ms steps; below 0.5 runs 0.5.
// - Ramp slope may be quantised by reference step resolution.
// - Timeout fault when output misses 85% within limit after turn-on delay.
// - A zero timeout limit disables timeout detection entirely.
module startup_timeout_and_soft_off_ctrl #(
   parameter logic [6:0]  TARGET_ADDR      = 7'h40,
   parameter logic [7:0]  DEF_FAULT_ACTION = 8'h80,
   parameter logic [10:0] DEF_TOFF_DLY_MAN = 11'h000,
   parameter logic [10:0] DEF_FALL_MAN     = 11'h004
) (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe_out,
   output logic             alert_n_out,
   input  wire logic        run_enable_in,
   input  wire logic        turn_on_delay_done_in,
   input  wire logic        vout_at_85pct_in,
   input  wire logic [7:0]  startup_timeout_limit_in,
   input  wire logic [6:0]  startup_rise_time_in,
   input  wire logic [11:0] vout_target_in,
   output logic             power_stage_on_out,
   output logic [11:0]      reference_out
);
   import sequencer_pkg::*;

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [2:0] delay_ms(input logic [2:0] d);
      delay_ms = (d == 3'h0) ? 3'h1 : d;
   endfunction : delay_ms

   function automatic logic [2:0] hiccup_mult(input logic [2:0] d);
      hiccup_mult = (d == 3'h7) ? 3'h7 : d + 3'h1;
   endfunction : hiccup_mult

   typedef struct packed {
      state_t      st;
      logic        vok_s1, vok_s2;
      logic [7:0]  action;
      logic [10:0] dly_man, fall_man;
      logic        startup_timeout, bad_cmd, bad_data, alert_n;
      logic [7:0]  cmd;
      logic [1:0]  wr_cnt;
      logic [15:0] data;
      logic        rd_idx;
      logic [7:0]  rd_byte;
      logic [11:0] prescale;
      logic [15:0] qms;
      logic [20:0] cnt, acc;
      logic [2:0]  tries;
      logic [11:0] ref_v;
      logic        pwr;
   } ctrl_t;

   ctrl_t s, n;
   smb_byte_if link ();

   smb_target #(
      .ADDR (TARGET_ADDR)
   ) u_target (
      .clk_in     (clk_in),
      .rst_in     (rst_in),
      .scl_in     (scl_in),
      .sda_in     (sda_in),
      .sda_oe_out (sda_oe_out),
      .bus        (link)
   );

   logic        shutdown;
   logic [15:0] rdata;
   logic        known;
   logic [15:0] limit_q, fault_q, hiccup_q;
   logic [20:0] toff_cycles, fall_cycles, acc_sum;
   logic [10:0] fall_eff;

   always_comb begin
      n = s;
      shutdown = 1'b0;
      n.vok_s1 = vout_at_85pct_in;
      n.vok_s2 = s.vok_s1;

      // ****************************************
      // Quarter-millisecond timebase
      // ****************************************
      if (s.prescale == 12'(QMS_CYCLES - 1)) begin
         n.prescale = 12'h000;
         n.qms = s.qms + 16'h0001;
      end else begin
         n.prescale = s.prescale + 12'h001;
      end

      // ****************************************
      // Command read path
      // ****************************************
      known = 1'b1;
      unique case (s.cmd)
         CMD_FAULT_ACTION: rdata = {8'h00, s.action};
         CMD_TURNOFF_DELAY_TIME:   rdata = {TOFF_DLY_EXP_RST, s.dly_man};
         CMD_TURNOFF_FALL_TIME:    rdata = {FALL_EXP_RST, s.fall_man};
         CMD_STATUS_BYTE, CMD_STATUS_WORD: begin
            rdata = 16'h0000;
            rdata[SB_OFF] = ~s.pwr;
            rdata[SB_CML] = s.bad_cmd | s.bad_data;
            rdata[SB_NOTA] = s.startup_timeout;
            rdata[SW_VOUT] = s.startup_timeout;
         end
         CMD_STATUS_VOUT: rdata = 16'(s.startup_timeout) << SV_STARTUP_TIMEOUT;
         CMD_STATUS_CML: begin
            rdata = 16'h0000;
            rdata[SC_BAD_CMD] = s.bad_cmd;
            rdata[SC_BAD_DATA] = s.bad_data;
         end
         default: begin
            rdata = 16'hffff;
            known = 1'b0;
         end
      endcase
      if (link.start) begin
         n.wr_cnt = 2'h0;
         n.rd_idx = 1'b0;
      end
      if (link.rd_req) begin
         n.rd_byte = s.rd_idx ? rdata[15:8] : rdata[7:0];
         n.rd_idx = 1'b1;
         if (!known) begin
            n.bad_cmd = 1'b1;
         end
      end

      // ****************************************
      // Command write path, committed at stop
      // ****************************************
      if (link.wr_valid) begin
         unique case (s.wr_cnt)
            2'h0: n.cmd = link.wr_byte;
            2'h1: n.data[7:0] = link.wr_byte;
            2'h2: n.data[15:8] = link.wr_byte;
            default: n.bad_data = 1'b1;
         endcase
         if (s.wr_cnt != 2'h3) begin
            n.wr_cnt = s.wr_cnt + 2'h1;
         end
      end
      if (link.stop && s.wr_cnt != 2'h0) begin
         unique case (s.cmd)
            CMD_CLEAR_FAULTS: begin
               n.startup_timeout = 1'b0;
               n.bad_cmd = 1'b0;
               n.bad_data = 1'b0;
            end
            CMD_FAULT_ACTION: begin
               if (s.wr_cnt != 2'h2 || s.data[ACT_HI:ACT_LO] == 2'h3) begin
                  n.bad_data = 1'b1;
               end else begin
                  n.action = s.data[7:0];
               end
            end
            CMD_TURNOFF_DELAY_TIME: begin
               if (s.wr_cnt != 2'h3 || s.data[EXP_HI:EXP_LO] != TOFF_DLY_EXP_RST
                   || s.data[MAN_HI:0] > TOFF_DLY_MAN_MAX) begin
                  n.bad_data = 1'b1;
               end else begin
                  n.dly_man = s.data[MAN_HI:0];
               end
            end
            CMD_TURNOFF_FALL_TIME: begin
               if (s.wr_cnt != 2'h3 || s.data[EXP_HI:EXP_LO] != FALL_EXP_RST
                   || s.data[MAN_HI:0] > FALL_MAN_MAX) begin
                  n.bad_data = 1'b1;
               end else begin
                  n.fall_man = s.data[MAN_HI:0];
               end
            end
            default: begin
               if (known) begin
                  n.bad_data = 1'b1;
               end else begin
                  n.bad_cmd = 1'b1;
               end
            end
         endcase
      end

      // ****************************************
      // Sequencing
      // ****************************************
      limit_q  = {7'h00, startup_timeout_limit_in, 1'b0};
      fault_q  = {11'h000, delay_ms(s.action[DLY_HI:DLY_LO]), 2'h0};
      // Hiccup as a multiple of rise time
      hiccup_q = 16'(hiccup_mult(s.action[DLY_HI:DLY_LO])) * 16'(startup_rise_time_in);
      // Fixed 50 us added to the programmed delay
      toff_cycles = 21'(s.dly_man * 2 * QMS_CYCLES + INTERNAL_OFF_CYCLES);
      // Short fall times stretched to the minimum
      fall_eff = (s.fall_man < FALL_MAN_MIN) ? FALL_MAN_MIN : s.fall_man;
      fall_cycles = 21'(fall_eff * QMS_CYCLES);
      acc_sum = s.acc + 21'(vout_target_in);
      n.cnt = s.cnt + 21'h000001;

      unique case (s.st)
         ST_OFF: begin
            n.pwr = 1'b0;
            n.ref_v = 12'h000;
            n.tries = 3'h0;
            if (run_enable_in) begin
               n.st = ST_START;
            end
         end
         ST_START: begin
            n.pwr = 1'b1;
            n.ref_v = vout_target_in;
            // Window opens at end of turn-on delay
            if (!turn_on_delay_done_in) begin
               n.qms = 16'h0000;
               n.prescale = 12'h000;
            end
            if (!run_enable_in) begin
               n.st = ST_TOFF_DLY;
            end else if (s.vok_s2) begin
               n.st = ST_RUN;
               n.tries = 3'h0;
            end else if (startup_timeout_limit_in != 8'h00 && s.qms >= limit_q) begin
               n.startup_timeout = 1'b1;
               unique case (s.action[ACT_HI:ACT_LO])
                  ACTION_IGNORE: n.st = ST_RUN;
                  ACTION_DELAYED: n.st = ST_FLT_DLY;
                  default: shutdown = 1'b1;
               endcase
            end
         end
         ST_RUN: begin
            n.pwr = 1'b1;
            n.ref_v = vout_target_in;
            n.tries = 3'h0;
            if (!run_enable_in) begin
               n.st = ST_TOFF_DLY;
            end
         end
         ST_FLT_DLY: begin
            n.pwr = 1'b1;
            n.ref_v = vout_target_in;
            if (!run_enable_in) begin
               n.st = ST_TOFF_DLY;
            end else if (s.vok_s2) begin
               n.st = ST_RUN;
            end else if (s.qms >= fault_q) begin
               shutdown = 1'b1;
            end
         end
         ST_HICCUP: begin
            n.pwr = 1'b0;
            n.ref_v = 12'h000;
            if (!run_enable_in) begin
               n.st = ST_OFF;
            end else if (s.qms >= hiccup_q) begin
               n.st = ST_START;
            end
         end
         ST_LATCHED: begin
            n.pwr = 1'b0;
            n.ref_v = 12'h000;
            // Release only on an off command
            if (!run_enable_in) begin
               n.st = ST_OFF;
            end
         end
         ST_TOFF_DLY: begin
            n.pwr = 1'b1;
            n.ref_v = vout_target_in;
            // Energy delivery continues for the delay
            if (s.cnt >= toff_cycles - 21'h000001) begin
               n.st = ST_TURNOFF_FALL_TIME;
            end
         end
         ST_TURNOFF_FALL_TIME: begin
            n.pwr = 1'b1;
            // Per-clock slope spreads target over fall time
            if (acc_sum >= fall_cycles) begin
               n.acc = acc_sum - fall_cycles;
               if (s.ref_v != 12'h000) begin
                  // One reference step per clock at most
                  n.ref_v = s.ref_v - 12'h001;
               end
            end else begin
               n.acc = acc_sum;
            end
            if (s.cnt >= fall_cycles - 21'h000001) begin
               n.ref_v = 12'h000;
               n.st = ST_OFF;
            end
         end
         default: n.st = ST_OFF;
      endcase

      if (shutdown) begin
         n.pwr = 1'b0;
         n.ref_v = 12'h000;
         if (s.action[RETRY_HI:RETRY_LO] == RETRY_LATCH) begin
            n.st = ST_LATCHED;
         end else if (s.action[RETRY_HI:RETRY_LO] == RETRY_FOREVER) begin
            n.st = ST_HICCUP;
         end else if (s.tries < s.action[RETRY_HI:RETRY_LO]) begin
            n.tries = s.tries + 3'h1;
            n.st = ST_HICCUP;
         end else begin
            n.st = ST_LATCHED;
         end
      end

      if (n.st != s.st) begin
         n.qms = 16'h0000;
         n.prescale = 12'h000;
         n.cnt = 21'h000000;
         n.acc = 21'h000000;
      end
      n.alert_n = ~(n.startup_timeout | n.bad_cmd | n.bad_data);
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s <= '{st: ST_OFF, action: DEF_FAULT_ACTION, dly_man: DEF_TOFF_DLY_MAN,
                fall_man: DEF_FALL_MAN, alert_n: 1'b1, cmd: 8'h00, wr_cnt: 2'h0,
                data: 16'h0000, rd_byte: 8'h00, prescale: 12'h000, qms: 16'h0000,
                cnt: 21'h000000, acc: 21'h000000, tries: 3'h0, ref_v: 12'h000,
                default: 1'b0};
      end else begin
         s <= n;
      end
   end

   assign link.rd_byte       = s.rd_byte;
   assign sda_out            = 1'b0;
   assign alert_n_out        = s.alert_n;
   assign power_stage_on_out = s.pwr;
   assign reference_out      = s.ref_v;

endmodule : startup_timeout_and_soft_off_ctrl

// ===== verification/soft_off_monitor.sv
// Port checker for the timeout and soft-off controller.
// Assumes one clock domain and an active-high asynchronous reset.
module soft_off_monitor (
   input wire logic        clk_in,
   input wire logic        rst_in,
   input wire logic        sda_oe_out,
   input wire logic        alert_n_out,
   input wire logic        run_enable_in,
   input wire logic        vout_at_85pct_in,
   input wire logic        power_stage_on_out,
   input wire logic [11:0] reference_out
);
   timeunit 1ns;
   timeprecision 1ns;
   wire logic on = power_stage_on_out;
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   a_reset_quiet: assert property (
      $fell(rst_in) |-> alert_n_out && !sda_oe_out && !on) else $error("active after reset");
   a_fault_alerts: assert property (
      $fell(on) && run_enable_in |-> ##[0:3] !alert_n_out) else $error("shutdown, no alert");
   a_alert_holds: assert property (
      $fell(alert_n_out) |=> !alert_n_out [*4]) else $error("alert dropped early");
   a_stays_off: assert property (
      !run_enable_in && !on |=> !on) else $error("powered while off");
   a_on_needs_run: assert property (
      $rose(on) |-> $past(run_enable_in)) else $error("start without run");
   a_delay_holds: assert property (
      $fell(run_enable_in) && on && vout_at_85pct_in |=> on [*8]) else $error("no delay");
   a_ramp_down: assert property (
      !run_enable_in && !$past(run_enable_in) |-> reference_out <= $past(reference_out))
      else $error("reference rose in turn-off");
   a_off_at_zero: assert property (
      $fell(on) && !run_enable_in |-> reference_out == 12'h0) else $error("off above zero");
   c_fault_off: cover property ($fell(on) && run_enable_in);
   c_soft_off: cover property ($fell(on) && !run_enable_in);
   c_alert: cover property ($fell(alert_n_out));
endmodule : soft_off_monitor
bind startup_timeout_and_soft_off_ctrl soft_off_monitor soft_off_monitor_inst (.*);

// ===== verification/pmbus_host_model.sv
// Two-wire host model; one bit takes 8 core clocks (800 ns).
// Assumes an open-drain data line with a pull-up.
module pmbus_host_model (
   input  wire logic clk_in,
   input  wire logic sda_oe_in,
   output logic      scl_out,
   output logic      sda_line_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic drv_low = 1'b0;
   initial scl_out = 1'b1;
   // Line low if any party pulls it
   assign sda_line_out = !(drv_low || sda_oe_in);
   task automatic st(input logic d1, input logic d2, output logic s);
      scl_out = 1'b0;
      repeat (2) @(negedge clk_in);
      drv_low = d1;
      repeat (2) @(negedge clk_in);
      scl_out = 1'b1;
      repeat (2) @(negedge clk_in);
      s = sda_line_out;
      drv_low = d2;
      repeat (2) @(negedge clk_in);
   endtask : st
   task automatic put(input logic [7:0] d);
      logic s;
      for (int b = 7; b >= 0; b--) st(!d[b], !d[b], s);
      st(1'b0, 1'b0, s);
   endtask : put
   // Words go low byte first
   task automatic xfer(input logic [7:0] c, input logic [15:0] v, input int nw,
                       input int nr, output logic [15:0] r);
      logic s;
      r = 16'h0;
      st(1'b0, 1'b1, s);
      put(8'h80);
      put(c);
      for (int i = 0; i < nw; i++) put(v[8*i+:8]);
      if (nr > 0) begin
         st(1'b0, 1'b1, s);
         put(8'h81);
      end
      for (int i = 0; i < nr; i++) begin
         for (int b = 7; b >= 0; b--) st(1'b0, 1'b0, r[8*i+b]);
         st(i < nr - 1, i < nr - 1, s);
      end
      st(1'b1, 1'b0, s);
   endtask : xfer
endmodule : pmbus_host_model

// ===== verification/startup_timeout_and_soft_off_ctrl_tb_top.sv
// Bench: host model on the link, register model and turn-off timing.
// Assumes default parameters and target address 0x40.
module startup_timeout_and_soft_off_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import sequencer_pkg::*;
   logic        clk_in = 1'b0;
   logic        rst_in = 1'b1;
   logic        run = 1'b0;
   logic        vok = 1'b0;
   logic        scl, sda, oe, alert_n, pwr;
   logic [7:0]  lim = 8'h01;
   logic [11:0] tgt = 12'h0;
   logic [11:0] ref_v;
   logic [15:0] mdl [3];
   logic [15:0] r;
   int          fail_count = 0;
   int          samples_checked = 0;
   int          seed = 32'h756f;
   int          n, rv;
   startup_timeout_and_soft_off_ctrl startup_timeout_and_soft_off_ctrl_inst (
      .clk_in(clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda), .sda_out(),
      .sda_oe_out(oe), .alert_n_out(alert_n), .run_enable_in(run),
      .turn_on_delay_done_in(1'b1), .vout_at_85pct_in(vok), .startup_timeout_limit_in(lim),
      .startup_rise_time_in(7'h04), .vout_target_in(tgt), .power_stage_on_out(pwr),
      .reference_out(ref_v));
   pmbus_host_model pmbus_host_model_inst (
      .clk_in(clk_in), .sda_oe_in(oe), .scl_out(scl), .sda_line_out(sda));
   initial forever #50 clk_in = ~clk_in;
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      samples_checked++;
      if (s !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic wr(input logic [7:0] c, input logic [15:0] v, input int nw);
      pmbus_host_model_inst.xfer(c, v, nw, 0, r);
   endtask : wr
   task automatic rd(input logic [7:0] c, input int nr, input logic [15:0] e);
      pmbus_host_model_inst.xfer(c, 16'h0, 0, nr, r);
      chk($sformatf("reg %h", c), e, r);
   endtask : rd
   task automatic rd_all();
      for (int i = 0; i < 3; i++) rd(8'(8'h63 + i), 1 + int'(i > 0), mdl[i]);
   endtask : rd_all
   task automatic wait_pwr(input logic lvl, input int bound);
      n = 0;
      while (pwr !== lvl && n < bound) begin
         @(negedge clk_in);
         n++;
      end
   endtask : wait_pwr
   task automatic tchk(input int e, input int tol);
      chk("cycles", 16'(e), 16'((n >= e - tol && n <= e + tol) ? e : n));
   endtask : tchk
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : finish_test
   // ******************************
   // Main sequence
   // ******************************
   initial begin
      repeat (20) @(negedge clk_in);
      rst_in = 1'b0;
      repeat (4) @(negedge clk_in);
      mdl = '{16'h0080, 16'hf800, 16'hf004};
      rd_all();
      wr(CMD_FAULT_ACTION, 16'h00c0, 1);
      wr(CMD_TURNOFF_DELAY_TIME, 16'hf900, 2);
      wr(CMD_TURNOFF_FALL_TIME, 16'hf080, 2);
      rd(CMD_STATUS_CML, 1, 16'h0040);
      rd_all();
      wr(CMD_CLEAR_FAULTS, 16'h0, 0);
      $display("register checks done");
      for (int a = 0; a < 3; a++) begin
         run = 1'b0;
         wait_pwr(1'b0, 20000);
         wr(CMD_FAULT_ACTION, 16'(a << 6), 1);
         run = 1'b1;
         wait_pwr(1'b1, 50);
         wait_pwr(1'b0, a == 0 ? 8000 : 20000);
         tchk(a == 0 ? 8000 : a == 1 ? 15000 : 5000, 2510);
         chk("alert", 16'h0, {15'h0, alert_n});
         $display("action %0d done", a);
      end
      rd(CMD_STATUS_WORD, 2, 16'h8041);
      rd(CMD_STATUS_VOUT, 1, 16'h0004);
      repeat (6000) @(negedge clk_in);
      chk("power", 16'h0, {15'h0, pwr});
      run = 1'b0;
      wr(CMD_CLEAR_FAULTS, 16'h0, 0);
      rv = $random(seed);
      mdl[1] = {5'h1f, 9'h0, 2'(rv)};
      mdl[2] = {5'h1e, 8'h0, 3'(rv >> 2)};
      wr(CMD_TURNOFF_DELAY_TIME, mdl[1], 2);
      wr(CMD_TURNOFF_FALL_TIME, mdl[2], 2);
      rd_all();
      lim = 8'h0;
      tgt = 12'(rv >> 20);
      run = 1'b1;
      repeat (6000) @(negedge clk_in);
      chk("alert", 16'h1, {15'h0, alert_n});
      vok = 1'b1;
      repeat (100) @(negedge clk_in);
      run = 1'b0;
      wait_pwr(1'b0, 60000);
      // Turn-off delay plus 50 us, then the ramp at no less than 0.5 ms
      tchk((rv & 3) * 5000 + 500 + (((rv >> 2) & 7) < 2 ? 2 : (rv >> 2) & 7) * 2500, 8);
      chk("reference", 16'h0, {4'h0, ref_v});
      $display("soft off done");
      finish_test();
   end
   initial begin
      #12000000;
      fail_count++;
      finish_test();
   end
endmodule : startup_timeout_and_soft_off_ctrl_tb_top
